// [verilog/bcc_pkg.sv]
// package of register map, field positions, reset values and timing for the charge cycle control
`default_nettype none
package bcc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_VSET    = 8'h04;
   localparam logic [7:0] ADDR_IFAST   = 8'h08;
   localparam logic [7:0] ADDR_IPRETRM = 8'h0C;
   localparam logic [7:0] ADDR_SHORT_BATTERY_CURRENT  = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h14;
   localparam logic [7:0] ADDR_SAFETY  = 8'h18;
   // control register fields
   localparam int CTRL_CHG_EN    = 0;
   localparam int CTRL_TERM_EN   = 1;
   localparam int CTRL_RECHG_SEL = 2;
   localparam int CTRL_WARM_VSEL = 3;
   localparam int CTRL_COOL_ISEL = 4;
   localparam int CTRL_BSW_OFF   = 5;
   localparam int CTRL_REG_RST   = 6;
   localparam int CTRL_TMR2X_EN  = 7;
   localparam int CTRL_SAFETY_EN = 8;
   localparam int CTRL_IND_LO    = 9;
   localparam int CTRL_TOPOFF_LO = 11;
   localparam logic [15:0] CTRL_WMASK = 16'h1FBF;
   // status register fields
   localparam int STAT_TOPOFF = 2;
   localparam int STAT_FLT_LO = 3;
   localparam int STAT_BSW_ON = 5;
   // reset values: mV and mA, safety timer in seconds
   localparam logic [15:0] RST_CTRL    = 16'h0183;
   localparam logic [15:0] RST_VSET    = 16'd4208;
   localparam logic [15:0] RST_IFAST   = 16'd2048;
   localparam logic [15:0] RST_IPRE    = 16'd180;
   localparam logic [15:0] RST_ITERM   = 16'd180;
   localparam logic [15:0] RST_SHORT_BATTERY_CURRENT  = 16'd100;
   localparam logic [15:0] RST_SAFETY  = 16'h8CA0;
   localparam logic [15:0] WARM_VLIM   = 16'd4100;
   localparam logic [15:0] COOL_DIV5   = 16'd5;
   localparam logic [1:0]  IND_OFF     = 2'b11;
   // charge phase and fault codes
   localparam logic [1:0] PH_DISABLED = 2'b00;
   localparam logic [1:0] PH_PRE      = 2'b01;
   localparam logic [1:0] PH_FAST     = 2'b10;
   localparam logic [1:0] PH_DONE     = 2'b11;
   localparam logic [1:0] FLT_NONE    = 2'b00;
   localparam logic [1:0] FLT_TIMER   = 2'b11;
   // timing: clock rate, one second tick, top-off step, indicator blink half period
   localparam int CLK_HZ          = 10_000_000;
   localparam int TICK_S          = 1;
   localparam int TICK_CYCLES     = CLK_HZ * TICK_S;
   localparam int BLINK_MS        = 500;
   localparam int BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_MS;
   localparam logic [15:0] TOPOFF_STEP_S = 16'd900;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [2:0] {
      ST_OFF, ST_CHARGE, ST_SUSPEND, ST_TOPOFF, ST_DONE, ST_FAULT
   } bcc_state_type;
endpackage : bcc_pkg
`default_nettype wire

// [verilog/bcc_charge_ctrl.sv]
// charge cycle control with axi4-lite register slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
// Summary of operation
// - charge runs autonomously while enable bit is 1 and enable pin low
// - defaults 4208 mV, 2048 mA fast, 180 mA precharge and termination
// - start needs converter, enable, nonzero fast current, no faults, switch not off
// - terminate when current low, voltage above recharge, no limiting or thermal
// - done battery falling below selected recharge threshold restarts a cycle
// - toggling enable pin or enable bit after done starts a new cycle
// - indicator low charging or in top-off, high done or off, blinking on fault, 11 disables
// - phase 00 disabled, 01 precharge, 10 fast, 11 done
// - completion of a cycle pulses the host interrupt
// - current chosen from battery voltage: short, precharge, fast
// - limiting or thermal regulation blocks termination and halves safety timer rate
// - after termination and any top-off battery switch off, may supplement system again
// - termination sets phase 11 and pulses the interrupt
// - termination enable bit at 0 prevents termination
// - top-off timer after termination, pauses and halves with safety timer
// - status flag shows top-off timer running
// - top-off timer reset on enable rise, termination rise, register reset
// - top-off setting captured at termination, later writes wait for recharge
// - interrupt on top-off start and on top-off expiry
// - charge only within cold and hot thresholds, else suspend and wait; top-off keeps charging, only its timer pauses
// - cool zone current halved, or 20 percent of fast current by select bit
// - safety timer expiry sets fault 11 and pulses the interrupt
module bcc_charge_ctrl #(
   parameter int TICK_CYCLES  = bcc_pkg::TICK_CYCLES,
   parameter int BLINK_CYCLES = bcc_pkg::BLINK_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        charge_enable_n,
   input  wire logic        converter_running,
   input  wire logic        batv_above_short,
   input  wire logic        batv_above_pre,
   input  wire logic        batv_above_rechg_lo,
   input  wire logic        batv_above_rechg_hi,
   input  wire logic        fast_charge_current_below_term,
   input  wire logic        input_power_limiting,
   input  wire logic        thermal_regulation,
   input  wire logic        thermistor_in_range,
   input  wire logic        thermistor_cool,
   input  wire logic        thermistor_warm,
   input  wire logic        supplement_request,
   output logic [15:0]      charge_voltage_target,
   output logic [15:0]      charge_current_target,
   output logic [15:0]      term_current_target,
   output logic             battery_switch_on,
   output logic             charging_active,
   output logic [1:0]       charge_phase_field,
   output logic             int_pulse,
   output logic             indicator_out,
   output logic             indicator_oe
);
   localparam int NCMP = 12;

   // register file
   logic [15:0] ctrl_q, vset_q, ifast_q, ipre_q, iterm_q, short_battery_current_q, safety_q;
   // bus slave state
   logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   // synchronised comparators
   logic [NCMP-1:0] cmp_meta_q, cmp_q;
   // core state
   bcc_pkg::bcc_state_type state_q, state_d;
   logic        en_q, int_q, bsw_on_q, half_q, blink_q;
   logic [1:0]  phase_q;
   logic [23:0] div_q, blink_cnt_q;
   logic [15:0] safety_cnt_q, topoff_cnt_q, topoff_lim_q;
   logic [15:0] vtgt_q, itgt_q;

   // bus decode
   wire do_write  = aw_held_q && w_held_q && !bvalid_q;
   wire do_read   = s_axi_arvalid && !rvalid_q;
   wire wr_ctrl   = do_write && (awaddr_q == bcc_pkg::ADDR_CTRL);
   wire wr_vset   = do_write && (awaddr_q == bcc_pkg::ADDR_VSET);
   wire wr_ifast  = do_write && (awaddr_q == bcc_pkg::ADDR_IFAST);
   wire wr_ipt    = do_write && (awaddr_q == bcc_pkg::ADDR_IPRETRM);
   wire wr_short_battery_current = do_write && (awaddr_q == bcc_pkg::ADDR_SHORT_BATTERY_CURRENT);
   wire wr_safety = do_write && (awaddr_q == bcc_pkg::ADDR_SAFETY);
   wire wr_map    = wr_ctrl || wr_vset || wr_ifast || wr_ipt || wr_short_battery_current || wr_safety
                    || (awaddr_q == bcc_pkg::ADDR_STATUS);
   wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] wbits = wdata_q & wmask;
   wire reg_rst = wr_ctrl && wbits[bcc_pkg::CTRL_REG_RST];

   // control fields
   wire chg_en_bit  = ctrl_q[bcc_pkg::CTRL_CHG_EN];
   wire term_en     = ctrl_q[bcc_pkg::CTRL_TERM_EN];
   wire rechg_sel   = ctrl_q[bcc_pkg::CTRL_RECHG_SEL];
   wire warm_vsel   = ctrl_q[bcc_pkg::CTRL_WARM_VSEL];
   wire cool_isel   = ctrl_q[bcc_pkg::CTRL_COOL_ISEL];
   wire bsw_off     = ctrl_q[bcc_pkg::CTRL_BSW_OFF];
   wire tmr2x_en    = ctrl_q[bcc_pkg::CTRL_TMR2X_EN];
   wire safety_en   = ctrl_q[bcc_pkg::CTRL_SAFETY_EN];
   wire [1:0] ind_fn     = ctrl_q[bcc_pkg::CTRL_IND_LO +: 2];
   wire [1:0] topoff_sel = ctrl_q[bcc_pkg::CTRL_TOPOFF_LO +: 2];

   // comparator view after the two-flop synchroniser
   wire c_short   = cmp_q[0];
   wire c_pre     = cmp_q[1];
   wire c_rc_lo   = cmp_q[2];
   wire c_rc_hi   = cmp_q[3];
   wire c_below   = cmp_q[4];
   wire c_limit   = cmp_q[5];
   wire c_thermal = cmp_q[6];
   wire c_ts_ok   = cmp_q[7];
   wire c_cool    = cmp_q[8];
   wire c_warm    = cmp_q[9];
   wire c_suppl   = cmp_q[10];
   wire c_conv    = cmp_q[11];

   // qualification terms
   wire enable     = chg_en_bit && !charge_enable_n;
   wire en_rise    = enable && !en_q;
   wire above_rc   = rechg_sel ? c_rc_hi : c_rc_lo;
   wire regulating = c_limit || c_thermal;
   wire go_off     = !enable || (ifast_q == 16'h0000) || bsw_off || !c_conv;
   wire start_ok   = !go_off && c_ts_ok;
   wire term_det   = term_en && c_below && above_rc && !regulating;
   wire tick       = (div_q == 24'(TICK_CYCLES - 1));
   wire slow       = tmr2x_en && (regulating || c_cool);
   wire timing     = (state_q == bcc_pkg::ST_CHARGE) || (state_q == bcc_pkg::ST_TOPOFF);
   wire advance    = tick && timing && c_ts_ok && (!slow || half_q);
   wire safety_exp = safety_en && (safety_cnt_q >= safety_q);
   wire topoff_exp = (topoff_cnt_q >= topoff_lim_q);
   wire term_rise  = (state_q == bcc_pkg::ST_CHARGE)
                     && ((state_d == bcc_pkg::ST_TOPOFF) || (state_d == bcc_pkg::ST_DONE));
   wire cyc_start  = (state_d == bcc_pkg::ST_CHARGE)
                     && ((state_q == bcc_pkg::ST_OFF) || (state_q == bcc_pkg::ST_DONE));
   wire topoff_rst = en_rise || term_rise || reg_rst;

   // cycle sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         bcc_pkg::ST_OFF: begin
            if (start_ok) state_d = bcc_pkg::ST_CHARGE;
         end
         bcc_pkg::ST_CHARGE: begin
            if (go_off) state_d = bcc_pkg::ST_OFF;
            else if (!c_ts_ok) state_d = bcc_pkg::ST_SUSPEND;
            else if (safety_exp) state_d = bcc_pkg::ST_FAULT;
            else if (term_det) begin
               state_d = (topoff_sel != 2'b00) ? bcc_pkg::ST_TOPOFF : bcc_pkg::ST_DONE;
            end
         end
         bcc_pkg::ST_SUSPEND: begin
            if (go_off) state_d = bcc_pkg::ST_OFF;
            else if (c_ts_ok) state_d = bcc_pkg::ST_CHARGE;
         end
         bcc_pkg::ST_TOPOFF: begin
            if (go_off) state_d = bcc_pkg::ST_OFF;
            else if (topoff_exp) state_d = bcc_pkg::ST_DONE;
         end
         bcc_pkg::ST_DONE: begin
            if (go_off) state_d = bcc_pkg::ST_OFF;
            else if (!above_rc && c_ts_ok) state_d = bcc_pkg::ST_CHARGE;
         end
         bcc_pkg::ST_FAULT: begin
            if (!enable) state_d = bcc_pkg::ST_OFF;
         end
         default: state_d = bcc_pkg::ST_OFF;
      endcase
   end

   // interrupt on entering top-off, done or fault
   wire int_d = (state_d != state_q) && ((state_d == bcc_pkg::ST_TOPOFF)
                || (state_d == bcc_pkg::ST_DONE) || (state_d == bcc_pkg::ST_FAULT));

   // phase code from state and battery voltage
   wire charging = (state_q == bcc_pkg::ST_CHARGE) || (state_q == bcc_pkg::ST_SUSPEND);
   wire finished = (state_q == bcc_pkg::ST_TOPOFF) || (state_q == bcc_pkg::ST_DONE);
   wire [1:0] phase_d = finished ? bcc_pkg::PH_DONE :
                        !charging ? bcc_pkg::PH_DISABLED :
                        c_pre ? bcc_pkg::PH_FAST : bcc_pkg::PH_PRE;
   wire [1:0] fault_fld = (state_q == bcc_pkg::ST_FAULT) ? bcc_pkg::FLT_TIMER
                                                         : bcc_pkg::FLT_NONE;

   // current and voltage targets with temperature derating
   wire [15:0] icool  = cool_isel ? (ifast_q / bcc_pkg::COOL_DIV5) : {1'b0, ifast_q[15:1]};
   wire [15:0] ifz    = c_cool ? icool : ifast_q;
   wire [15:0] itgt_d = !c_short ? short_battery_current_q : !c_pre ? ipre_q : ifz;
   wire [15:0] vtgt_d = (c_warm && warm_vsel) ? bcc_pkg::WARM_VLIM : vset_q;
   // switch opens once done after any top-off, closes again when the system needs the battery
   wire bsw_d = !bsw_off && (charging || (state_q == bcc_pkg::ST_TOPOFF)
                || c_suppl || !c_conv);

   // read mux
   wire [15:0] status = {10'h000, bsw_on_q, fault_fld,
                         (state_q == bcc_pkg::ST_TOPOFF), phase_q};
   wire        rd_hit = (s_axi_araddr <= bcc_pkg::ADDR_SAFETY) && (s_axi_araddr[1:0] == 2'b00);
   wire [15:0] rd_lo  = (s_axi_araddr == bcc_pkg::ADDR_CTRL)    ? ctrl_q   :
                        (s_axi_araddr == bcc_pkg::ADDR_VSET)    ? vset_q   :
                        (s_axi_araddr == bcc_pkg::ADDR_IFAST)   ? ifast_q  :
                        (s_axi_araddr == bcc_pkg::ADDR_IPRETRM) ? ipre_q   :
                        (s_axi_araddr == bcc_pkg::ADDR_SHORT_BATTERY_CURRENT)  ? short_battery_current_q :
                        (s_axi_araddr == bcc_pkg::ADDR_STATUS)  ? status   :
                        (s_axi_araddr == bcc_pkg::ADDR_SAFETY)  ? safety_q : 16'h0000;
   wire [15:0] rd_hi  = (s_axi_araddr == bcc_pkg::ADDR_IPRETRM) ? iterm_q : 16'h0000;

   // write address and data are taken independently and joined here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bresp_q   <= bcc_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_map ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read channel answers one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= bcc_pkg::RESP_OKAY;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {rd_hi, rd_lo};
         rresp_q  <= rd_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // settings; the register reset bit reloads every default and never stores itself
   always_ff @(posedge aclk) begin
      if (!aresetn || reg_rst) begin
         ctrl_q   <= bcc_pkg::RST_CTRL;
         vset_q   <= bcc_pkg::RST_VSET;
         ifast_q  <= bcc_pkg::RST_IFAST;
         ipre_q   <= bcc_pkg::RST_IPRE;
         iterm_q  <= bcc_pkg::RST_ITERM;
         short_battery_current_q <= bcc_pkg::RST_SHORT_BATTERY_CURRENT;
         safety_q <= bcc_pkg::RST_SAFETY;
      end else begin
         if (wr_ctrl)
            ctrl_q <= (ctrl_q & ~wmask[15:0]) | (wbits[15:0] & bcc_pkg::CTRL_WMASK);
         if (wr_vset)   vset_q   <= (vset_q & ~wmask[15:0]) | wbits[15:0];
         if (wr_ifast)  ifast_q  <= (ifast_q & ~wmask[15:0]) | wbits[15:0];
         if (wr_ipt)    ipre_q   <= (ipre_q & ~wmask[15:0]) | wbits[15:0];
         if (wr_ipt)    iterm_q  <= (iterm_q & ~wmask[31:16]) | wbits[31:16];
         if (wr_short_battery_current) short_battery_current_q <= (short_battery_current_q & ~wmask[15:0]) | wbits[15:0];
         if (wr_safety) safety_q <= (safety_q & ~wmask[15:0]) | wbits[15:0];
      end
   end

   // comparators and status pins cross in through two flops; only the second is used
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_meta_q <= '0;
         cmp_q      <= '0;
      end else begin
         cmp_meta_q <= {converter_running, supplement_request, thermistor_warm,
                        thermistor_cool, thermistor_in_range, thermal_regulation,
                        input_power_limiting, fast_charge_current_below_term, batv_above_rechg_hi,
                        batv_above_rechg_lo, batv_above_pre, batv_above_short};
         cmp_q      <= cmp_meta_q;
      end
   end

   // sequencer state, interrupt pulse and registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= bcc_pkg::ST_OFF;
         en_q     <= 1'b0;
         int_q    <= 1'b0;
         phase_q  <= bcc_pkg::PH_DISABLED;
         vtgt_q   <= 16'h0000;
         itgt_q   <= 16'h0000;
         bsw_on_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         en_q     <= enable;
         int_q    <= int_d;
         phase_q  <= phase_d;
         vtgt_q   <= vtgt_d;
         itgt_q   <= itgt_d;
         bsw_on_q <= bsw_d;
      end
   end

   // one second tick and the half-rate gate shared by both timers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= 24'h000000;
         half_q <= 1'b0;
      end else begin
         div_q <= tick ? 24'h000000 : div_q + 24'h000001;
         if (tick && timing && slow) half_q <= !half_q;
      end
   end

   // safety timer restarts with every new cycle, holds while suspended
   always_ff @(posedge aclk) begin
      if (!aresetn || cyc_start) begin
         safety_cnt_q <= 16'h0000;
      end else if (advance && (state_q == bcc_pkg::ST_CHARGE) && !safety_exp) begin
         safety_cnt_q <= safety_cnt_q + 16'h0001;
      end
   end

   // top-off limit latched at termination so later writes wait for a recharge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         topoff_cnt_q <= 16'h0000;
         topoff_lim_q <= 16'h0000;
      end else begin
         if (term_rise)
            topoff_lim_q <= 16'({14'h0000, topoff_sel} * bcc_pkg::TOPOFF_STEP_S);
         if (topoff_rst)
            topoff_cnt_q <= 16'h0000;
         else if (advance && (state_q == bcc_pkg::ST_TOPOFF) && !topoff_exp)
            topoff_cnt_q <= topoff_cnt_q + 16'h0001;
      end
   end

   // fault blink divider, only runs in the fault state
   always_ff @(posedge aclk) begin
      if (!aresetn || (state_q != bcc_pkg::ST_FAULT)) begin
         blink_cnt_q <= 24'h000000;
         blink_q     <= 1'b0;
      end else if (blink_cnt_q == 24'(BLINK_CYCLES - 1)) begin
         blink_cnt_q <= 24'h000000;
         blink_q     <= !blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 24'h000001;
      end
   end

   // bus outputs
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // open-drain indicator: pulled low while charging or in top-off, blinking on fault, released otherwise
   wire ind_low = (state_q == bcc_pkg::ST_FAULT) ? blink_q : (charging || finished && 
                  state_q == bcc_pkg::ST_TOPOFF);
   assign indicator_out = 1'b0;
   assign indicator_oe  = (ind_fn != bcc_pkg::IND_OFF) && ind_low;

   // device outputs
   assign charge_voltage_target = vtgt_q;
   assign charge_current_target = itgt_q;
   assign term_current_target   = iterm_q;
   assign battery_switch_on     = bsw_on_q;
   assign charging_active       = timing;
   assign charge_phase_field    = phase_q;
   assign int_pulse             = int_q;
endmodule // bcc_charge_ctrl
`default_nettype wire

// [sim/bcc_checker.sv]
// port checker for the charge cycle control
`default_nettype none
module bcc_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        charging_active,
   input wire logic [1:0]  charge_phase_field,
   input wire logic        int_pulse,
   input wire logic        indicator_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer moved early");
   property p_arrdy; s_axi_arready == !s_axi_rvalid; endproperty
   a_arrdy: assert property (p_arrdy) else $error("read ready wrong");
   property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_refuse: assert property (p_refuse) else $error("write taken during answer");
   property p_pulse; int_pulse |=> !int_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("interrupt longer than a cycle");
   property p_doneint; $rose(charge_phase_field == bcc_pkg::PH_DONE)
      |-> $past(int_pulse); endproperty
   a_doneint: assert property (p_doneint) else $error("no interrupt at done");
   property p_phase; charging_active && $past(charging_active)
      |-> charge_phase_field != 2'h0; endproperty
   a_phase: assert property (p_phase) else $error("phase off while charging");
   property p_indout; indicator_out == 1'b0; endproperty
   a_indout: assert property (p_indout) else $error("indicator drives high");
   c_done: cover property (charge_phase_field == bcc_pkg::PH_DONE);
   c_int: cover property (int_pulse);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // bcc_checker
bind bcc_charge_ctrl bcc_checker u_bcc_checker (.*);
`default_nettype wire

// [sim/bcc_batt_model.sv]
// cell model: comparator levels from a cell voltage in mV
`default_nettype none
module bcc_batt_model #(
   parameter int RECHG_LO_MV = 4100,
   parameter int RECHG_HI_MV = 4000
) (
   input  wire logic        aclk,
   input  wire logic [15:0] batt_mv,
   input  wire logic        full,
   output logic             batv_above_short,
   output logic             batv_above_pre,
   output logic             batv_above_rechg_lo,
   output logic             batv_above_rechg_hi,
   output logic             fast_charge_current_below_term
);
   timeunit 1ns;
   timeprecision 1ns;
   // comparators move only after a clock edge, like a real settled analog front end
   always_ff @(posedge aclk) begin
      batv_above_short    <= batt_mv > 16'h0898;
      batv_above_pre      <= batt_mv > 16'h0BB8;
      batv_above_rechg_lo <= batt_mv > 16'(RECHG_LO_MV);
      batv_above_rechg_hi <= batt_mv > 16'(RECHG_HI_MV);
      fast_charge_current_below_term     <= full; // current tapers only at a full cell
   end
endmodule // bcc_batt_model
`default_nettype wire

// [sim/bcc_charge_ctrl_tb.sv]
// bench: register defaults, phases, termination, recharge, indicator
`default_nettype none
module bcc_charge_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic        s_axi_arvalid = '0, s_axi_rready = '0, charge_enable_n = '1, full = '0;
   logic        converter_running = '0, thermistor_in_range = '0, supplement_request = '0;
   logic        input_power_limiting = '0, thermal_regulation = '0, thermistor_cool = '0;
   logic        thermistor_warm = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, batv_above_short, batv_above_pre, batv_above_rechg_lo;
   logic        batv_above_rechg_hi, fast_charge_current_below_term, battery_switch_on, charging_active;
   logic        int_pulse, indicator_out, indicator_oe;
   logic [1:0]  s_axi_bresp, s_axi_rresp, charge_phase_field;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [15:0] batt_mv = '0, charge_voltage_target, charge_current_target, term_current_target;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   int          err_total = 0, num_checks = 0, cyc = 0, ints = 0;
   bcc_charge_ctrl #(.TICK_CYCLES(10), .BLINK_CYCLES(4)) u_bcc_charge_ctrl (.*);
   bcc_batt_model u_bcc_batt_model (.*);
   always #50 aclk = ~aclk;
   // hang guard and interrupt counter
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (int_pulse === 1'b1) ints <= ints + 1;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // ready is sampled mid-cycle so its value is settled at the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(negedge aclk);
         {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      chk(32'(r), 32'(er));
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(negedge aclk);
         {ta, tr, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
      chk(d, e);
      chk(32'(r), 32'(er));
   endtask
   // cell moves, then synchroniser and state registers settle
   task automatic drv(input logic [15:0] v, input logic f);
      @(posedge aclk);
      {batt_mv, full} <= {v, f};
      repeat (8) @(posedge aclk);
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc(bcc_pkg::ADDR_CTRL, 32'h0000_0183, bcc_pkg::RESP_OKAY);
      rc(bcc_pkg::ADDR_VSET, 32'(bcc_pkg::RST_VSET), bcc_pkg::RESP_OKAY);
      rc(bcc_pkg::ADDR_IFAST, 32'(bcc_pkg::RST_IFAST), bcc_pkg::RESP_OKAY);
      rc(bcc_pkg::ADDR_IPRETRM, 32'h00B4_00B4, bcc_pkg::RESP_OKAY);
      rc(bcc_pkg::ADDR_SHORT_BATTERY_CURRENT, 32'h0000_0064, bcc_pkg::RESP_OKAY);
      rc(8'h1C, 32'h0, bcc_pkg::RESP_SLVERR);
      $display("test defaults done");
      {converter_running, charge_enable_n, thermistor_in_range} <= 3'h5;
      drv(16'h07D0, 1'b0);
      chk(32'(charge_current_target), 32'h64);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_PRE));
      drv(16'h09C4, 1'b0);
      chk(32'(charge_current_target), 32'hB4);
      drv(16'h0DAC, 1'b0);
      chk(32'(charge_current_target), 32'h800);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_FAST));
      chk(32'(indicator_oe), 32'h1);
      chk({charge_voltage_target, term_current_target}, 32'h1070_00B4);
      drv(16'h1068, 1'b1);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_DONE));
      chk(32'(ints), 32'h1);
      chk(32'(battery_switch_on), 32'h0);
      supplement_request <= 1'b1;
      drv(16'h0DAC, 1'b0);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_FAST));
      $display("test charge cycle done");
      wr(bcc_pkg::ADDR_CTRL, 32'h181, bcc_pkg::RESP_OKAY);
      drv(16'h1068, 1'b1);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_FAST));
      wr(bcc_pkg::ADDR_CTRL, 32'h781, bcc_pkg::RESP_OKAY);
      drv(16'h1068, 1'b1);
      chk(32'(indicator_oe), 32'h0);
      wr(bcc_pkg::ADDR_CTRL, 32'h780, bcc_pkg::RESP_OKAY);
      drv(16'h1068, 1'b1);
      chk(32'(charge_phase_field), 32'(bcc_pkg::PH_DISABLED));
      wr(8'h1C, 32'h0, bcc_pkg::RESP_SLVERR);
      $display("test controls done");
      print_verdict();
   end
endmodule // bcc_charge_ctrl_tb
`default_nettype wire
